// File: design/eifd_pkg.sv
/*
 * constants, field layouts and carrier types for the external interrupt
 * filter and detect block.
 * assumes a 32-bit apb with 16-bit byte addresses and registers on word indices.
 */
package eifd_pkg;

    localparam int NUM_CH = 6;
    localparam int ADDR_W = 16;
    localparam int IDX_W = 14;

    // word indices; byte address is four times the index
    localparam logic [IDX_W-1:0] GATE_IDX = 14'h0f77;
    localparam logic [IDX_W-1:0] CTRL1_IDX = 14'h0fd8;
    localparam logic [IDX_W-1:0] CTRL_BASE_IDX = 14'h0fd7;
    localparam logic [IDX_W-1:0] STAT_IDX = 14'h0fe0;
    localparam logic [IDX_W-1:0] MASK_IDX = 14'h0fe1;

    localparam logic [7:0] GATE_RST = 8'h00;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] STAT_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'h00;

    // channel control field positions
    localparam int LVL_BIT = 4;
    localparam int ES_LSB = 2;
    localparam int NC_LSB = 0;

    // edge select codes
    localparam logic [1:0] ES_RISE = 2'h0;
    localparam logic [1:0] ES_FALL = 2'h1;
    localparam logic [1:0] ES_BOTH = 2'h2;

    // sampling divisors in gear-clock cycles, fast modes
    localparam logic [4:0] DIV_NC0 = 5'h01;
    localparam logic [4:0] DIV_NC1 = 5'h04;
    localparam logic [4:0] DIV_NC2 = 5'h08;
    localparam logic [4:0] DIV_NC3 = 5'h10;
    // low-frequency clock rising edges per sample, slow modes
    localparam logic [2:0] SLOW_DIV = 3'h4;
    // consecutive equal samples before the filtered level moves
    localparam logic [2:0] FILT_SAMPLES = 3'h3;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } eifd_apb_req_type;

    typedef struct packed {
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } eifd_apb_rsp_type;

    typedef struct packed {
        logic [1:0] edge_sel;
        logic [1:0] rate;
    } eifd_ctrl_type;

endpackage : eifd_pkg

// File: design/eifd_filter.sv
/*
 * one channel of the digital noise canceller with its sample-rate divider.
 * assumes pin is synchronous to clk and lf_rise is a one-cycle pulse per
 * low-frequency clock rising edge.
 */
`timescale 1ns/1ps
module eifd_filter (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic run,
    input wire logic slow_mode,
    input wire logic lf_rise,
    input wire logic [1:0] rate,
    input wire logic pin,
    output logic filt
);
    import eifd_pkg::*;

    logic [4:0] div_q;
    logic [2:0] lf_cnt_q;
    logic [2:0] stable_q;
    logic filt_q;
    logic [4:0] div_lim;
    logic tick;

    always_comb begin
        case (rate)
            2'h0: div_lim = DIV_NC0;
            2'h1: div_lim = DIV_NC1;
            2'h2: div_lim = DIV_NC2;
            default: div_lim = DIV_NC3;
        endcase
    end

    // slow modes ignore the rate field
    assign tick = slow_mode ? (lf_rise && lf_cnt_q == SLOW_DIV - 3'h1) // [RULE9]
                            : (div_q >= div_lim - 5'h01); // [RULE8]

    // divider for the fast modes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= 5'h00;
        end else if (ce) begin
            if (!run || slow_mode || tick) begin
                div_q <= 5'h00;
            end else begin
                div_q <= div_q + 5'h01;
            end
        end
    end

    // prescaler on low-frequency edges for the slow modes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lf_cnt_q <= 3'h0;
        end else if (ce) begin
            if (!run || !slow_mode) begin
                lf_cnt_q <= 3'h0;
            end else if (lf_rise) begin
                lf_cnt_q <= tick ? 3'h0 : lf_cnt_q + 3'h1;
            end
        end
    end

    // level moves only after a run of equal samples
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stable_q <= 3'h0;
            filt_q <= 1'b0;
        end else if (ce) begin
            if (!run) begin // [RULE4]
                stable_q <= 3'h0;
                filt_q <= 1'b0;
            end else if (tick) begin
                if (pin == filt_q) begin
                    stable_q <= 3'h0;
                end else if (stable_q == FILT_SAMPLES - 3'h1) begin // [RULE16]
                    stable_q <= 3'h0;
                    filt_q <= pin;
                end else begin
                    stable_q <= stable_q + 3'h1;
                end
            end
        end
    end

    assign filt = filt_q;

endmodule : eifd_filter

// File: design/eifd_detect.sv
/*
 * edge detector and level capture behind one noise canceller.
 * assumes filt comes from the filter flip-flop of the same channel.
 */
`timescale 1ns/1ps
module eifd_detect (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic run,
    input wire logic [1:0] edge_sel,
    input wire logic filt,
    output logic req,
    output logic level
);
    import eifd_pkg::*;

    logic prev_q;
    logic level_q;
    logic rise;
    logic fall;

    assign rise = filt & ~prev_q;
    assign fall = ~filt & prev_q;

    always_comb begin
        case (edge_sel) // [RULE6]
            ES_RISE: req = run & rise;
            ES_FALL: req = run & fall;
            ES_BOTH: req = run & (rise | fall);
            default: req = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_q <= 1'b0;
        end else if (ce) begin
            prev_q <= run & filt;
        end
    end

    // level at the moment of the request, cleared while gated
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            level_q <= 1'b0;
        end else if (ce) begin
            if (!run) begin // [RULE4]
                level_q <= 1'b0;
            end else if (req) begin
                level_q <= filt; // [RULE7]
            end
        end
    end

    assign level = level_q;

endmodule : eifd_detect

// File: design/eifd_top.sv
/*
 * external interrupt filter and detect: six channels, gate register,
 * per-channel control registers, sticky request latches and mask, apb slave.
 * assumes pins and slow_mode are synchronous to clk; low_freq_clock is a
 * slow level sampled here; the cpu pulses irq_accept when it takes a request.
 */
// The APB slave port is this design's own decision.
// What this block does
// RULE1 - each pin passes the noise canceller, then an edge or level detector.
// RULE2 - gate register holds one enable per channel in bits 0-5, reset zero.
// RULE3 - gate register bits 7 and 6 always read as zero.
// RULE4 - a disabled channel stops and its control contents are discarded.
// RULE5 - software enables a channel before writing its control register.
// RULE6 - edge field: 00 rising, 01 falling, 10 both, 11 reserved.
// RULE7 - level bit captures filtered level at request; zero initially or low.
// RULE8 - fast modes: rate field picks clock, clock/4, clock/8 or clock/16.
// RULE9 - slow and sleep modes sample at low-frequency clock over four.
// RULE10 - control fields reset zero, bits 7-5 read zero, level read-only.
// RULE11 - spurious requests on gate, control or mode change are not suppressed.
// RULE12 - software disables the interrupt before changing gate, control or mode.
// RULE13 - after fast-to-slow switch, software waits twelve low-frequency periods, clears latch.
// RULE14 - after slow-to-fast switch, software waits two gear plus three fspl periods.
// RULE15 - a raised latch holds until accepted, reset, or cleared by software.
// RULE16 - filter output moves only after several consecutive equal samples.
`timescale 1ns/1ps
module eifd_top (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire eifd_pkg::eifd_apb_req_type apb_req,
    output eifd_pkg::eifd_apb_rsp_type apb_rsp,
    input wire logic [eifd_pkg::NUM_CH-1:0] ext_pin,
    input wire logic slow_mode,
    input wire logic low_freq_clock,
    input wire logic [eifd_pkg::NUM_CH-1:0] irq_accept,
    output logic [eifd_pkg::NUM_CH-1:0] irq_latch,
    output logic irq
);
    import eifd_pkg::*;

    logic rst_s1_q;
    logic rst_n;
    logic lf_s1_q;
    logic lf_s2_q;
    logic lf_prev_q;
    logic lf_rise;
    logic [NUM_CH-1:0] gate_q;
    logic [NUM_CH-1:0] stat_q;
    logic [NUM_CH-1:0] mask_q;
    eifd_ctrl_type ctrl_q [NUM_CH];
    logic [NUM_CH-1:0] filt;
    logic [NUM_CH-1:0] req;
    logic [NUM_CH-1:0] level;
    logic [IDX_W-1:0] idx;
    logic setup;
    logic wr_en;
    logic [31:0] rd_d;
    logic hit;
    logic [31:0] prdata_q;
    logic pslverr_q;

    // reset released through two flops
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_s1_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n <= rst_s1_q;
        end
    end

    // low-frequency clock sampled as a level; the rising edge is taken from the second and third flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lf_s1_q <= 1'b0;
            lf_s2_q <= 1'b0;
            lf_prev_q <= 1'b0;
        end else if (ce) begin
            lf_s1_q <= low_freq_clock;
            lf_s2_q <= lf_s1_q;
            lf_prev_q <= lf_s2_q;
        end
    end

    assign lf_rise = lf_s2_q & ~lf_prev_q;

    // apb decode
    assign idx = apb_req.paddr[ADDR_W-1:2];
    assign setup = apb_req.psel & ~apb_req.penable;
    // zero-wait access: read data is prepared during setup
    assign wr_en = apb_req.psel & apb_req.penable & apb_req.pwrite & ~pslverr_q;

    always_comb begin
        rd_d = 32'h0000_0000;
        hit = 1'b0;
        if (apb_req.paddr[1:0] != 2'h0) begin
            hit = 1'b0;
        end else if (idx == GATE_IDX) begin
            hit = 1'b1;
            rd_d[NUM_CH-1:0] = gate_q; // [RULE3]
        end else if (idx == STAT_IDX) begin
            hit = 1'b1;
            rd_d[NUM_CH-1:0] = stat_q;
        end else if (idx == MASK_IDX) begin
            hit = 1'b1;
            rd_d[NUM_CH-1:0] = mask_q;
        end else begin
            for (int c = 0; c < NUM_CH; c++) begin
                if (idx == CTRL_BASE_IDX + IDX_W'(c)) begin
                    hit = 1'b1;
                    rd_d[LVL_BIT] = level[c]; // [RULE10]
                    rd_d[ES_LSB+1:ES_LSB] = ctrl_q[c].edge_sel;
                    rd_d[NC_LSB+1:NC_LSB] = ctrl_q[c].rate;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (ce && setup) begin
            prdata_q <= rd_d;
            pslverr_q <= ~hit;
        end
    end

    assign apb_rsp.pready = 1'b1;
    assign apb_rsp.prdata = prdata_q;
    assign apb_rsp.pslverr = pslverr_q & apb_req.psel & apb_req.penable;

    // gate register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gate_q <= GATE_RST[NUM_CH-1:0]; // [RULE2]
        end else if (ce && wr_en && idx == GATE_IDX) begin
            gate_q <= apb_req.pwdata[NUM_CH-1:0]; // [RULE2]
        end
    end

    // mask register, same layout as status
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_q <= MASK_RST[NUM_CH-1:0];
        end else if (ce && wr_en && idx == MASK_IDX) begin
            mask_q <= apb_req.pwdata[NUM_CH-1:0];
        end
    end

    genvar i;
    generate
        for (i = 0; i < NUM_CH; i++) begin : g_ch
            logic stat_clr;

            // writes to a gated channel are dropped
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    ctrl_q[i] <= eifd_ctrl_type'(CTRL_RST[3:0]); // [RULE10]
                end else if (ce) begin
                    if (!gate_q[i]) begin
                        ctrl_q[i] <= eifd_ctrl_type'(CTRL_RST[3:0]); // [RULE4] [RULE5]
                    end else if (wr_en && idx == CTRL_BASE_IDX + IDX_W'(i)) begin
                        ctrl_q[i].edge_sel <= apb_req.pwdata[ES_LSB+1:ES_LSB];
                        ctrl_q[i].rate <= apb_req.pwdata[NC_LSB+1:NC_LSB];
                    end
                end
            end

            // gate low stops the channel logic
            eifd_filter u_filter ( // [RULE1]
                .clk(clk),
                .rst_n(rst_n),
                .ce(ce),
                .run(gate_q[i]),
                .slow_mode(slow_mode),
                .lf_rise(lf_rise),
                .rate(ctrl_q[i].rate),
                .pin(ext_pin[i]),
                .filt(filt[i])
            );

            // edges from mode or control changes pass through on purpose
            eifd_detect u_detect ( // [RULE1] [RULE11]
                .clk(clk),
                .rst_n(rst_n),
                .ce(ce),
                .run(gate_q[i]),
                .edge_sel(ctrl_q[i].edge_sel),
                .filt(filt[i]),
                .req(req[i]),
                .level(level[i])
            );

            assign stat_clr = irq_accept[i]
                | (wr_en && idx == STAT_IDX && apb_req.pwdata[i]);

            // a new request wins over a clear in the same cycle
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    stat_q[i] <= STAT_RST[i];
                end else if (ce) begin
                    stat_q[i] <= req[i] | (stat_q[i] & ~stat_clr); // [RULE15]
                end
            end
        end
    endgenerate

    assign irq_latch = stat_q;
    assign irq = |(stat_q & mask_q);

endmodule : eifd_top

// File: testbench/eifd_sva.sv
/* port checks for eifd_top: apb answer, latch hold, irq and freeze.
   assumes one clock domain and nrst as the only reset seen at the ports. */
`timescale 1ns/1ps
module eifd_sva (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire eifd_pkg::eifd_apb_req_type apb_req,
    input wire eifd_pkg::eifd_apb_rsp_type apb_rsp,
    input wire logic [eifd_pkg::NUM_CH-1:0] ext_pin,
    input wire logic slow_mode,
    input wire logic low_freq_clock,
    input wire logic [eifd_pkg::NUM_CH-1:0] irq_accept,
    input wire logic [eifd_pkg::NUM_CH-1:0] irq_latch,
    input wire logic irq
);
    import eifd_pkg::*;
    wire acc = apb_req.psel && apb_req.penable;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    property p_ready; apb_rsp.pready; endproperty
    a_ready: assert property (p_ready) else $error("pready low");
    property p_err_align; acc && apb_req.paddr[1:0] != 2'h0 |-> apb_rsp.pslverr; endproperty
    a_err_align: assert property (p_err_align) else $error("misaligned not refused");
    property p_err_idle; !acc |-> !apb_rsp.pslverr; endproperty
    a_err_idle: assert property (p_err_idle) else $error("pslverr outside access");
    property p_gate_rd;
        acc && apb_req.paddr == {GATE_IDX, 2'h0}
            |-> !apb_rsp.pslverr && apb_rsp.prdata[31:6] == 26'h0;
    endproperty
    a_gate_rd: assert property (p_gate_rd) else $error("gate top bits set");
    property p_ctrl_rd;
        acc && apb_req.paddr == {CTRL1_IDX, 2'h0} |-> apb_rsp.prdata[31:5] == 27'h0;
    endproperty
    a_ctrl_rd: assert property (p_ctrl_rd) else $error("ctrl top bits set");
    property p_hold;
        irq_accept == 6'h0 && !(acc && apb_req.pwrite)
            |=> (irq_latch & $past(irq_latch)) == $past(irq_latch);
    endproperty
    a_hold: assert property (p_hold) else $error("latch dropped alone");
    property p_irq; irq_latch == 6'h0 |-> !irq; endproperty
    a_irq: assert property (p_irq) else $error("irq without latch");
    property p_freeze; !ce |=> $stable(irq_latch); endproperty
    a_freeze: assert property (p_freeze) else $error("latch moved while stopped");
    property p_rd_hold; !apb_req.psel |=> $stable(apb_rsp.prdata); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("prdata moved while idle");
    c_err: cover property (acc && apb_rsp.pslverr);
    c_irq: cover property ($rose(irq));
    c_clr: cover property ($fell(irq_latch[1]));
endmodule : eifd_sva

bind eifd_top eifd_sva u_sva (.clk(clk), .nrst(nrst), .ce(ce), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .ext_pin(ext_pin), .slow_mode(slow_mode),
    .low_freq_clock(low_freq_clock), .irq_accept(irq_accept), .irq_latch(irq_latch),
    .irq(irq));

// File: testbench/eifd_pins.sv
/* far-side pin model: each pin sits at the asked level, glitch flips it.
   assumes the bench changes lvl and glitch just after a clk edge. */
`timescale 1ns/1ps
module eifd_pins (
    input wire logic [5:0] lvl,
    input wire logic [5:0] glitch,
    output logic [5:0] pin
);
    // pins are driven at all times, so no released level is needed
    assign pin = lvl ^ glitch;
endmodule : eifd_pins

// File: testbench/external_interrupt_filter_detect_tb.sv
/* self-checking bench for eifd_top: reads queue their expected values,
   a monitor compares; pins come from eifd_pins. assumes a 200 mhz clk. */
`timescale 1ns/1ps
module external_interrupt_filter_detect_tb;
    import eifd_pkg::*;
    localparam logic [15:0] A_GATE = {GATE_IDX, 2'h0};
    localparam logic [15:0] A_CTRL1 = {CTRL1_IDX, 2'h0};
    localparam logic [15:0] A_STAT = {STAT_IDX, 2'h0};
    localparam logic [15:0] A_MASK = {MASK_IDX, 2'h0};
    logic clk, nrst, ce, slow_mode, low_freq_clock, irq;
    eifd_apb_req_type req;
    eifd_apb_rsp_type rsp;
    logic [5:0] lvl, glitch, pin, acc, lat;
    logic [9:0] expq[$];
    int miscompares, checks;
    eifd_top u_dut (.clk(clk), .nrst(nrst), .ce(ce), .apb_req(req), .apb_rsp(rsp),
        .ext_pin(pin), .slow_mode(slow_mode), .low_freq_clock(low_freq_clock),
        .irq_accept(acc), .irq_latch(lat), .irq(irq));
    eifd_pins u_pins (.lvl(lvl), .glitch(glitch), .pin(pin));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // slow clock off any multiple of clk
    initial begin
        low_freq_clock = 1'b0;
        forever #21 low_freq_clock = ~low_freq_clock;
    end
    task automatic cmp(input string what, input logic [9:0] exp, input logic [9:0] got);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask : cmp
    task automatic final_report();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : final_report
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    // exp is {pslverr, any of prdata 31:8, prdata 7:0}
    task automatic apb(input logic w, input logic [15:0] a, input logic [7:0] d,
                       input logic [9:0] exp);
        @(posedge clk);
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= w;
        req.paddr <= a;
        req.pwdata <= {24'($urandom()), d};
        if (!w) expq.push_back(exp);
        @(posedge clk);
        req.penable <= 1'b1;
        @(posedge clk);
        while (rsp.pready !== 1'b1) @(posedge clk);
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb
    always @(posedge clk) begin
        if (req.psel && req.penable && rsp.pready && !req.pwrite) begin
            cmp("read", expq.pop_front(), {rsp.pslverr, |rsp.prdata[31:8], rsp.prdata[7:0]});
        end
    end
    initial begin
        #100000;
        miscompares++;
        final_report();
    end
    initial begin
        logic lv, hit;
        int dv;
        req = '0;
        lvl = 6'h0;
        glitch = 6'h0;
        acc = 6'h0;
        ce = 1'b1;
        slow_mode = 1'b0;
        nrst = 1'b0;
        lv = 1'b0;
        void'($urandom(32'h9c2c));
        cyc(6);
        nrst <= 1'b1;
        cyc(3);
        apb(0, A_GATE, 0, 10'h000);
        apb(0, A_CTRL1, 0, 10'h000);
        apb(0, A_STAT, 0, 10'h000);
        apb(0, A_MASK, 0, 10'h000);
        apb(1, A_CTRL1, 8'h0f, 0);
        apb(0, A_CTRL1, 0, 10'h000);
        apb(1, A_GATE, 8'hff, 0);
        apb(0, A_GATE, 0, 10'h03f);
        apb(1, A_CTRL1, 8'hff, 0);
        apb(0, A_CTRL1, 0, 10'h00f);
        apb(0, 16'h0100, 0, 10'h200);
        apb(0, A_GATE + 16'h1, 0, 10'h200);
        for (int e = 0; e < 4; e++) begin
            apb(1, A_MASK, 8'h00, 0);
            apb(1, A_CTRL1, {4'h0, 2'(e), 2'h0}, 0);
            apb(1, A_STAT, 8'h3f, 0);
            apb(1, A_MASK, 8'h02, 0);
            for (int v = 1; v >= 0; v--) begin
                hit = (e == 2) || (e == 1 - v);
                @(posedge clk);
                lvl[1] <= v[0];
                cyc(3);
                #1 cmp("early", 10'h0, {9'h0, lat[1]});
                @(posedge clk);
                #1 cmp("latch", {8'h0, hit, hit}, {8'h0, lat[1], irq});
                if (hit) lv = v[0];
                apb(0, A_CTRL1, 0, {5'h0, lv, 2'(e), 2'h0});
                if (hit) begin
                    apb(1, A_MASK, 8'h00, 0);
                    @(posedge clk);
                    ce <= 1'b0;
                    cyc(3);
                    ce <= 1'b1;
                    #1 cmp("masked", 10'h002, {8'h0, lat[1], irq});
                    apb(1, A_MASK, 8'h02, 0);
                end
                // accept clears the rise, software clears the fall
                if (v == 1) begin
                    @(posedge clk);
                    acc <= 6'h02;
                    @(posedge clk);
                    acc <= 6'h00;
                end else apb(1, A_STAT, 8'h02, 0);
                apb(0, A_STAT, 0, 10'h000);
            end
        end
        for (int r = 0; r < 4; r++) begin
            dv = (r == 0) ? 1 : 2 << r;
            apb(1, A_CTRL1, {4'h0, ES_BOTH, 2'(r)}, 0);
            apb(1, A_STAT, 8'h3f, 0);
            @(posedge clk);
            lvl[1] <= ~lvl[1];
            cyc(2 * dv);
            #1 cmp("rate_early", 10'h0, {9'h0, lat[1]});
            cyc(dv + 4);
            #1 cmp("rate_late", 10'h1, {9'h0, lat[1]});
        end
        // full-rate sampling, so both glitch cycles are seen and only the count saves us
        apb(1, A_CTRL1, {4'h0, ES_BOTH, 2'h0}, 0);
        apb(1, A_STAT, 8'h3f, 0);
        @(posedge clk);
        glitch[1] <= 1'b1;
        cyc(2);
        glitch[1] <= 1'b0;
        cyc(6);
        #1 cmp("glitch", 10'h0, {9'h0, lat[1]});
        @(posedge clk);
        slow_mode <= 1'b1;
        cyc(101);
        apb(1, A_STAT, 8'h3f, 0);
        @(posedge clk);
        lvl[1] <= ~lvl[1];
        cyc(60);
        #1 cmp("slow_early", 10'h0, {9'h0, lat[1]});
        cyc(90);
        #1 cmp("slow_late", 10'h1, {9'h0, lat[1]});
        @(posedge clk);
        slow_mode <= 1'b0;
        cyc(30);
        apb(1, A_STAT, 8'h3f, 0);
        apb(0, A_STAT, 0, 10'h000);
        apb(1, A_GATE, 8'h00, 0);
        apb(0, A_CTRL1, 0, 10'h000);
        cyc(2);
        final_report();
    end
endmodule : external_interrupt_filter_detect_tb
